// File: include/rwd_pkg.sv
// package: constants shared by the runaway code watchdog files
package rwd_pkg;
  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_SERVICE = 16'hFFFF;
  localparam logic [15:0] IDX_CFG     = 16'h001F;
  localparam logic [15:0] IDX_CAUSE   = 16'h0020;
  localparam int          ADDR_W      = 18;

  // configuration register fields
  localparam int         CFG_DIS_BIT = 0;
  localparam int         CFG_PIN_BIT = 1;
  localparam int         CFG_RS_BIT  = 7;
  localparam logic [7:0] CFG_RST     = 8'h00;

  // reset cause register fields
  localparam int         CAUSE_WD_BIT   = 0;
  localparam int         CAUSE_PIN_BIT  = 1;
  localparam int         CAUSE_LOCK_BIT = 2;
  localparam logic [7:0] CAUSE_RST      = 8'h00;

  // counter structure and timing counts in oscillator cycles
  localparam int PRE_W       = 12;
  localparam int WD_W        = 6;
  localparam int SVC_KEEP    = 4;
  localparam int SHORT_TAP   = 7;
  localparam int PIN_LOW_CYC = 32;

  typedef enum logic {PIN_IDLE, PIN_DRIVE} rwd_pin_e;
endpackage

// File: core/rwd_sync.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module rwd_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end
    else if (ce)
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // rwd_sync
`default_nettype wire

// File: core/rwd_pin_drive.sv
// timer that holds the open-drain reset pin low for a fixed count
`timescale 1ns/10ps
`default_nettype none
module rwd_pin_drive #(
  parameter int LOW_CYC = rwd_pkg::PIN_LOW_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic start,
  output logic      oe
);
  localparam int CW = $clog2(LOW_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(LOW_CYC - 1);

  if (LOW_CYC < 1)
  begin : g_bad
    $error("rwd_pin_drive: LOW_CYC must be at least 1");
  end

  rwd_pkg::rwd_pin_e st_r;
  rwd_pkg::rwd_pin_e st_nxt;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     cnt_nxt;

  assign oe = (st_r == rwd_pkg::PIN_DRIVE);

  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      rwd_pkg::PIN_IDLE:
      begin
        // a second start while driving is absorbed
        if (start)
        begin
          st_nxt  = rwd_pkg::PIN_DRIVE;
          cnt_nxt = '0;
        end
      end
      rwd_pkg::PIN_DRIVE:
      begin
        if (cnt_r == LAST)
          st_nxt = rwd_pkg::PIN_IDLE;
        else
          cnt_nxt = cnt_r + CW'(1);
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r  <= rwd_pkg::PIN_IDLE;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pin_start;
    ce && start && st_r == rwd_pkg::PIN_IDLE;
  endsequence

  a_pin_starts: assert property (s_pin_start |=> oe && cnt_r == '0)
    else $error("reset pin not driven after start");
  a_pin_length: assert property (oe |-> cnt_r <= LAST)
    else $error("reset pin drive count out of range");
  a_pin_release: assert property ($fell(oe) |-> $past(cnt_r) == LAST)
    else $error("reset pin released at the wrong count");
endmodule // rwd_pin_drive
`default_nettype wire

// File: core/rwd_watchdog.sv
// runaway code watchdog: prescaler, watchdog counter and APB registers
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - 6-bit free-running watchdog counter fed by 12-bit prescaler on oscillator clock.
// - unserviced overflow resets system after 262,128 or 8176 cycles per rate select.
// - any write to service address clears watchdog counter and prescaler stages 12-5.
// - each service write starts a fresh timeout, shortened by the value left in prescaler stages 4-1.
// - reading service address returns reset vector low byte.
// - watchdog reset drives reset pin low 32 cycles if pin function enabled.
// - watchdog reset sets the watchdog cause flag.
// - stop instruction clears the prescaler.
// - after power-up prescaler is cleared once 4096 cycles have passed.
// - internal reset clears prescaler and watchdog counter.
// - disable and rate select follow the write-once configuration register.
// - disable bit 1 turns watchdog off; 0 enables it.
// - rate select 1 picks 8176 cycles, 0 picks 262,128 cycles.
// - no interrupt request; timeout only resets.
// - disabled in monitor mode with test voltage on interrupt pin.
// - keeps counting in wait mode and still resets there.
// - stop mode gates the watchdog clock and clears the prescaler.
// - disabled during break in monitor mode when break disable bit set.
module rwd_watchdog #(
  parameter int         PRE_W        = rwd_pkg::PRE_W,
  parameter int         WD_W         = rwd_pkg::WD_W,
  parameter logic [7:0] RESET_VEC_LO = 8'h00
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       ce,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [rwd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       stop_instr,
  input  wire logic                       stop_mode,
  input  wire logic                       monitor_mode,
  input  wire logic                       test_mode_voltage,
  input  wire logic                       break_active,
  input  wire logic                       break_watchdog_disable,
  input  wire logic                       internal_reset,
  input  wire logic                       rst_pin_in,
  output logic                            rst_pin_out,
  output logic                            rst_pin_oe,
  output logic                            watchdog_reset
);
  localparam int KEEP = rwd_pkg::SVC_KEEP;
  localparam int TAP  = rwd_pkg::SHORT_TAP;
  localparam int HI_W = PRE_W - KEEP;

  if (PRE_W <= TAP || TAP <= KEEP || WD_W < 1)
  begin : g_bad
    $error("rwd_watchdog: PRE_W must exceed SHORT_TAP and WD_W be at least 1");
  end

  // bus decode
  logic [15:0] idx;
  logic        setup;
  logic        acc;
  logic        hit_svc;
  logic        hit_cfg;
  logic        hit_cause;
  logic        hit_any;
  logic        svc_wr;
  logic        cfg_wr;
  logic        cause_rd;
  logic [7:0]  rd_byte;

  // register state
  logic [7:0]  cfg_r;
  logic [7:0]  cfg_nxt;
  logic        lock_r;
  logic        lock_nxt;
  logic        cause_wd_r;
  logic        cause_wd_nxt;
  logic [7:0]  cause_byte;
  logic [31:0] prdata_nxt;
  logic        pslverr_nxt;
  logic        ld_r;
  logic        ld_nxt;

  // counters
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [WD_W-1:0]  wd_r;
  logic [WD_W-1:0]  wd_nxt;
  logic             por_pend_r;
  logic             por_pend_nxt;
  logic             wd_reset_nxt;

  // mode and gating terms
  logic tst_s;
  logic pin_s;
  logic dis;
  logic rate_short;
  logic pin_en;
  logic en;
  logic run;
  logic clr;
  logic pre_clr;
  logic tick;
  logic hi_ones;
  logic ovf;

  rwd_sync u_tst_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (test_mode_voltage),
    .dout    (tst_s)
  );

  rwd_sync u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (rst_pin_in),
    .dout    (pin_s)
  );

  // read data is latched once per transfer; a setup edge lost to a low
  // clock enable costs one wait state instead of handing back stale data
  assign pready    = ce & ld_r;
  assign idx       = paddr[rwd_pkg::ADDR_W-1:2];
  assign setup     = psel & ce & ~ld_r;
  assign acc       = psel & penable & ce & ld_r;
  assign ld_nxt    = psel & ~acc;
  assign hit_svc   = (idx == rwd_pkg::IDX_SERVICE);
  assign hit_cfg   = (idx == rwd_pkg::IDX_CFG);
  assign hit_cause = (idx == rwd_pkg::IDX_CAUSE);
  assign hit_any   = hit_svc | hit_cfg | hit_cause;
  assign svc_wr    = acc & pwrite & hit_svc;
  assign cfg_wr    = acc & pwrite & hit_cfg & ~lock_r;
  assign cause_rd  = acc & ~pwrite & hit_cause;

  assign cause_byte = {5'h00, lock_r, pin_s, cause_wd_r};

  // service location aliases the vector byte, never counter state
  assign rd_byte = hit_svc   ? RESET_VEC_LO :
                   hit_cfg   ? cfg_r :
                   hit_cause ? cause_byte :
                   8'h00;

  // loaded before the access completes, so it stands through it
  assign prdata_nxt  = (setup & ~pwrite) ? {24'h000000, rd_byte} : prdata;
  assign pslverr_nxt = setup ? ~hit_any : pslverr;

  // later writes to the locked configuration are silently dropped
  assign cfg_nxt  = cfg_wr ? pwdata[7:0] : cfg_r;
  assign lock_nxt = lock_r | (acc & pwrite & hit_cfg);

  assign dis        = cfg_r[rwd_pkg::CFG_DIS_BIT];
  assign rate_short = cfg_r[rwd_pkg::CFG_RS_BIT];
  assign pin_en     = cfg_r[rwd_pkg::CFG_PIN_BIT];

  // wait mode has no input: counting simply goes on
  assign en = ~dis
              & ~(monitor_mode & tst_s)
              & ~(monitor_mode & break_active & break_watchdog_disable);

  // stop gates the oscillator into the watchdog
  assign run = en & ~por_pend_r & ~stop_mode;

  // overflow feeds back as an internal reset of the counters
  assign clr     = internal_reset | ovf;
  assign pre_clr = clr | stop_instr | stop_mode | (por_pend_r & (&pre_r));

  // tap for the watchdog clock: top stage or the short-rate stage
  assign tick = rate_short ? (&pre_r[TAP-1:0]) : (&pre_r);

  // last stretch ends when the service-cleared upper stages are all ones
  assign hi_ones = rate_short ? (&pre_r[TAP-1:KEEP]) : (&pre_r[PRE_W-1:KEEP]);
  assign ovf     = run & (&wd_r) & hi_ones;

  // low stages keep running across a service, so the period
  // shortens by their value at the write
  always_comb
  begin
    if (pre_clr)
      pre_nxt = '0;
    else if (svc_wr)
      pre_nxt = {{HI_W{1'b0}}, pre_r[KEEP-1:0]};
    else
      pre_nxt = pre_r + PRE_W'(1);
  end

  always_comb
  begin
    if (clr | svc_wr | ~en)
      wd_nxt = '0;
    else if (run & tick)
      wd_nxt = wd_r + WD_W'(1);
    else
      wd_nxt = wd_r;
  end

  // the first prescaler wrap after power-up ends the settle phase
  assign por_pend_nxt = por_pend_r & ~(&pre_r);

  // the only action on timeout is a reset, never an interrupt
  assign wd_reset_nxt = ovf;

  // set wins over the clear on read
  assign cause_wd_nxt = watchdog_reset | (cause_wd_r & ~cause_rd);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r  <= rwd_pkg::CFG_RST;
      lock_r <= 1'b0;
    end
    else if (ce)
    begin
      cfg_r  <= cfg_nxt;
      lock_r <= lock_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata     <= 32'h00000000;
      pslverr    <= 1'b0;
      ld_r       <= 1'b0;
      cause_wd_r <= rwd_pkg::CAUSE_RST[rwd_pkg::CAUSE_WD_BIT];
    end
    else if (ce)
    begin
      prdata     <= prdata_nxt;
      pslverr    <= pslverr_nxt;
      ld_r       <= ld_nxt;
      cause_wd_r <= cause_wd_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r          <= '0;
      wd_r           <= '0;
      por_pend_r     <= 1'b1;
      watchdog_reset <= 1'b0;
    end
    else if (ce)
    begin
      pre_r          <= pre_nxt;
      wd_r           <= wd_nxt;
      por_pend_r     <= por_pend_nxt;
      watchdog_reset <= wd_reset_nxt;
    end
  end

  // pin drive depends on the enable; the system reset does not
  rwd_pin_drive #(
    .LOW_CYC (rwd_pkg::PIN_LOW_CYC)
  ) u_pin (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (ovf & pin_en),
    .oe      (rst_pin_oe)
  );

  // open drain: only ever pulls low
  assign rst_pin_out = 1'b0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_svc_clears_count: assert property (
    svc_wr |=> wd_r == '0 && pre_r[PRE_W-1:KEEP] == '0)
    else $error("service write did not clear the counters");

  a_ovf_resets_system: assert property (
    ovf && ce |=> watchdog_reset && wd_r == '0 && pre_r == '0)
    else $error("overflow did not raise a system reset");

  a_cause_flag_set: assert property (
    watchdog_reset && ce |=> cause_wd_r)
    else $error("watchdog reset did not set the cause flag");

  a_stop_clears_pre: assert property (
    stop_instr && ce |=> pre_r == '0)
    else $error("stop instruction did not clear the prescaler");

  a_stop_freezes_wd: assert property (
    stop_mode && ce && !svc_wr && !internal_reset && en |=> $stable(wd_r) && pre_r == '0)
    else $error("watchdog moved in stop mode");

  a_disabled_quiet: assert property (
    !en && ce |=> wd_r == '0 && !watchdog_reset)
    else $error("disabled watchdog counted or reset");

  a_svc_read_vector: assert property (
    acc && !pwrite && hit_svc |-> prdata == {24'h000000, RESET_VEC_LO})
    else $error("service read returned other than the vector byte");

  a_por_settle_end: assert property (
    por_pend_r && (&pre_r) && ce |=> !por_pend_r && pre_r == '0)
    else $error("power-up settle did not end at prescaler wrap");

  a_int_reset_clears: assert property (
    internal_reset && ce |=> wd_r == '0 && pre_r == '0)
    else $error("internal reset left the counters running");
endmodule // rwd_watchdog
`default_nettype wire

// File: tb/rwd_sys_model.sv
// system side model: reset pin with pull-up and internal reset stretcher
`timescale 1ns/10ps
`default_nettype none
module rwd_sys_model #(
  parameter int HOLD = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic watchdog_reset,
  input  wire logic rst_pin_oe,
  input  wire logic rst_pin_out,
  input  wire logic sys_req,
  output logic      internal_reset,
  output logic      rst_pin_in
);
  int hold_cnt;
  // released pin floats up to the pull-up level
  assign rst_pin_in = rst_pin_oe ? rst_pin_out : 1'b1;
  assign internal_reset = hold_cnt != 0;
  // stretched so the core sees a reset of several cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_cnt <= 0;
    else if (watchdog_reset || sys_req)
      hold_cnt <= HOLD;
    else if (hold_cnt != 0)
      hold_cnt <= hold_cnt - 1;
  end
endmodule // rwd_sys_model
`default_nettype wire

// File: tb/runaway_code_watchdog_test.sv
// testbench: registers, timeouts, pin drive and mode gating of the watchdog
`timescale 1ns/10ps
`default_nettype none
module runaway_code_watchdog_test;
  localparam int          PW      = 8;
  localparam int          WW      = 2;
  localparam int          T_LONG  = (1 << (PW + WW)) - 16;
  localparam int          T_SHORT = (1 << (7 + WW)) - 16;
  localparam logic [17:0] A_SVC   = {rwd_pkg::IDX_SERVICE, 2'b00};
  localparam logic [17:0] A_CFG   = {rwd_pkg::IDX_CFG, 2'b00};
  localparam logic [17:0] A_CAU   = {rwd_pkg::IDX_CAUSE, 2'b00};
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, rst_pin_out, rst_pin_oe, watchdog_reset;
  logic        stop_instr = 0, stop_mode = 0, monitor_mode = 0, tmv = 0;
  logic        brk = 0, bwd = 0, sys_req = 0, jitter = 0, internal_reset, rst_pin_in;
  logic [7:0]  cfgs [3] = '{8'h82, 8'h00, 8'h01};
  logic [5:0]  modes [5] = '{6'b110000, 6'b101100, 6'b101001, 6'b000010, 6'b000001};
  int          err_total = 0, n_compared = 0, oe_run = 0, oe_last = 0, n_rst = 0, n, t, b;

  rwd_watchdog #(.PRE_W(PW), .WD_W(WW), .RESET_VEC_LO(8'h5A)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_instr(stop_instr), .stop_mode(stop_mode),
    .monitor_mode(monitor_mode), .test_mode_voltage(tmv), .break_active(brk),
    .break_watchdog_disable(bwd), .internal_reset(internal_reset),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .watchdog_reset(watchdog_reset));
  rwd_sys_model sys (.pclk(pclk), .presetn(presetn), .watchdog_reset(watchdog_reset),
    .rst_pin_oe(rst_pin_oe), .rst_pin_out(rst_pin_out), .sys_req(sys_req),
    .internal_reset(internal_reset), .rst_pin_in(rst_pin_in));

  always #25 pclk = ~pclk;
  // random stalls only where no timing is measured
  always @(posedge pclk) if (jitter) ce <= ($urandom % 2) == 0;
  always @(negedge pclk)
  begin
    if (watchdog_reset === 1'b1) n_rst++;
    if (rst_pin_oe === 1'b1) oe_run++;
    else if (oe_run != 0)
    begin
      oe_last = oe_run;
      oe_run = 0;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task chk_rng(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %0d range %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    chk_rng(k, 1, 49, "apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task svc;
    apb(1'b1, A_SVC, $urandom);
  endtask
  task wait_rst(input int lim);
    n = 0;
    while (watchdog_reset !== 1'b1 && n < lim)
    begin
      @(negedge pclk);
      n++;
    end
  endtask
  task reset_dut(input logic [7:0] c);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (300) @(posedge pclk);
    apb(1'b1, A_CFG, {24'h0, c});
    apb(1'b1, A_CFG, {24'h0, ~c});
    apb(1'b0, A_CFG, 0);
    chk(rd, {24'h0, c}, "config write once");
    oe_last = 0;
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #3000000;
    err_total++;
    complete_run;
  end

  initial
  begin
    void'($urandom(32'h06C1));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    jitter = 1;
    apb(1'b0, A_CFG, 0);
    chk(rd, 0, "config reset");
    apb(1'b0, A_SVC, 0);
    chk(rd, 32'h5A, "vector byte");
    apb(1'b1, A_CAU, 32'hFF);
    apb(1'b0, A_CAU, 0);
    chk(rd, 32'h02, "cause reset");
    apb(1'b0, 18'h00100, 0);
    chk({rd[30:0], er}, 1, "unmapped index");
    jitter = 0;
    @(posedge pclk);
    ce <= 1'b1;
    foreach (cfgs[i])
    begin
      reset_dut(cfgs[i]);
      t = cfgs[i][7] ? T_SHORT : T_LONG;
      b = n_rst;
      repeat (3)
      begin
        svc;
        repeat ($urandom_range(t - 40, 10)) @(posedge pclk);
      end
      chk(n_rst, b, "serviced early");
      svc;
      wait_rst(t + 40);
      if (cfgs[i][0])
        chk({31'h0, watchdog_reset}, 0, "disabled");
      else
      begin
        chk_rng(n, t - 16, t + 2, "timeout");
        repeat (3) @(posedge pclk); // let the pin level pass its synchroniser
        apb(1'b0, A_CAU, 0);
        chk(rd, cfgs[i][1] ? 32'h05 : 32'h07, "cause flag");
        apb(1'b0, A_CAU, 0);
        chk(rd, cfgs[i][1] ? 32'h04 : 32'h06, "flag read clear");
        repeat (40) @(posedge pclk);
        chk(oe_last, cfgs[i][1] ? 32 : 0, "pin low span");
      end
    end
    reset_dut(8'h00);
    t = T_LONG;
    // monitor/voltage, break gating, stop mode, plain run; bit0 set: a reset is due
    foreach (modes[i])
    begin
      @(posedge pclk);
      {monitor_mode, tmv, brk, bwd, stop_mode} <= modes[i][5:1];
      stop_instr <= modes[i][1];
      @(posedge pclk);
      stop_instr <= 1'b0;
      svc;
      wait_rst(t + 40);
      chk({31'h0, watchdog_reset}, {31'h0, modes[i][0]}, "mode gating");
    end
    svc;
    repeat (t / 2) @(posedge pclk);
    sys_req <= 1'b1;
    @(posedge pclk);
    sys_req <= 1'b0;
    wait_rst(2 * t);
    chk_rng(n, t - 16, t + 8, "internal reset restart");
    chk({31'h0, rst_pin_oe}, 0, "pin off");
    complete_run;
  end
endmodule // runaway_code_watchdog_test
`default_nettype wire
